// ### core/lmie_regs.svh
// Purpose: Offsets, field positions and reset values of the move/indirect executor
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Definitions only
`ifndef LMIE_REGS_SVH
`define LMIE_REGS_SVH

`define LMIE_OFF_INSTR 8'h00
`define LMIE_OFF_WORK 8'h04
`define LMIE_OFF_BANK 8'h08
`define LMIE_OFF_PAGE 8'h0c
`define LMIE_OFF_FSP0 8'h10
`define LMIE_OFF_FSP1 8'h14
`define LMIE_OFF_FLAGS 8'h18
`define LMIE_OFF_POWER_CONTROL_STATUS_REGISTER 8'h1c
`define LMIE_OFF_MADDR 8'h20
`define LMIE_OFF_MDATA 8'h24

// Instruction word: opcode in [19:16], operand in [15:0]
`define LMIE_OP_LSB 16
`define LMIE_OP_W 4
`define LMIE_ARG_W 16
// Indirect forms: mode code [1:0], pointer index [2]; relative: offset [5:0], index [6]
`define LMIE_MM_LSB 0
`define LMIE_IND_N_BIT 2
`define LMIE_REL_N_BIT 6
`define LMIE_REL_K_W 6

// Window addresses inside every bank
`define LMIE_WIN0_ADDR 7'h00
`define LMIE_WIN1_ADDR 7'h01

`define LMIE_RST_WORK 8'h00
`define LMIE_RST_BANK 6'h00
`define LMIE_RST_PAGE 7'h00
`define LMIE_RST_FSP 16'h0000
`define LMIE_RST_FLAGS 3'h0
`define LMIE_RST_RI 1'h1

`endif

// ### core/lmie_pkg.sv
// Purpose: Types of the move/indirect executor
// Assumes: Nothing
// Notes: Values live in lmie_regs.svh
package lmie_pkg;

  typedef enum logic [3:0] {
    OP_NO_OPERATION = 4'h0,
    OP_LOAD_BANK_LITERAL = 4'h1,
    OP_LOAD_PAGE_LATCH_LITERAL = 4'h2,
    OP_LOAD_WORKING_LITERAL = 4'h3,
    OP_STORE_WORKING_TO_FILE = 4'h4,
    OP_STORE_WORKING_INDIRECT = 4'h5,
    OP_STORE_WORKING_RELATIVE = 4'h6,
    OP_SOFTWARE_RESET = 4'h7
  } op_t;

  typedef enum logic [1:0] {
    MM_PRE_INC = 2'h0,
    MM_PRE_DEC = 2'h1,
    MM_POST_INC = 2'h2,
    MM_POST_DEC = 2'h3
  } mm_t;

  typedef enum logic [1:0] {
    ST_WAIT = 2'b01,
    ST_ANSWER = 2'b10
  } apb_state_t;

endpackage : lmie_pkg

// ### core/lmie_data_mem.sv
// Purpose: Data memory written by the executor
// Assumes: One write port, one registered read port
// Notes: Not cleared by reset
`timescale 1ns/100ps
`default_nettype none

module lmie_data_mem #(
  parameter int AW = 8
) (
  // Clock
  input wire logic clk,
  // Write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // Read port
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata_q
);

  if (AW < 1 || AW > 16) begin : g_bad_aw
    $error("AW must lie between 1 and 16");
  end

  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    rdata_q <= mem[raddr];
  end

endmodule : lmie_data_mem

`default_nettype wire

// ### core/literal_move_indirect_exec.sv
// Purpose: Executes literal loads, stores, indirect stores, no-op and software reset
// Assumes: APB slave; one instruction per write to the instruction register
// Notes: Answers with pready one cycle into the access phase
//
// Behaviour
// - Load bank writes 6-bit literal, flags kept
// - Load page latch writes 7-bit literal
// - Load working writes 8-bit literal, one cycle
// - Store working copies W to file, flags kept
// - Indirect store writes W via chosen pointer
// - Modes 00/01 pre-increment or pre-decrement pointer
// - Modes 10/11 post-increment or post-decrement pointer
// - Relative offset store leaves pointer unchanged
// - Window addresses redirect through their pointer
// - Pointers are 16-bit and wrap around
// - Pointer updates and stores keep flags
// - Software reset resets device, clears flag
//
// Local design decisions: the register addresses and register access over APB.
`include "lmie_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module literal_move_indirect_exec #(
  parameter int MEM_AW = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core state seen by the rest of the device
  output logic [5:0] bank_select_register,
  output logic [6:0] program_counter_high_latch,
  output logic soft_reset
);

  if (MEM_AW < 7 || MEM_AW > 16) begin : g_bad_aw
    $error("MEM_AW must lie between 7 and 16");
  end

  logic [7:0] work_q;
  logic [5:0] bank_q;
  logic [6:0] page_q;
  logic [15:0] fsp_q [2];
  logic [2:0] flags_q;
  logic ri_q;
  logic soft_reset_q;
  logic [MEM_AW-1:0] maddr_q;
  logic [7:0] mdata;
  lmie_pkg::apb_state_t state_q;
  logic [31:0] prdata_q;
  logic pslverr_q;

  // Pointer arithmetic, modulo 2^16
  function automatic logic [15:0] ptr_add(input logic [15:0] p, input logic [15:0] d);
    ptr_add = 16'(p + d);
  endfunction : ptr_add

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= `LMIE_OFF_MDATA) && (a[1:0] == 2'h0);
  endfunction : mapped

  // APB handshake: a transfer completes at the edge where pready is high
  logic done;
  logic wr_done;
  assign done = psel && penable && (state_q == lmie_pkg::ST_ANSWER);
  assign wr_done = done && pwrite && mapped(paddr);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= lmie_pkg::ST_WAIT;
    end else begin
      case (state_q)
        lmie_pkg::ST_WAIT: begin
          if (psel && penable) begin
            state_q <= lmie_pkg::ST_ANSWER;
          end
        end
        lmie_pkg::ST_ANSWER: begin
          state_q <= lmie_pkg::ST_WAIT;
        end
        default: begin
          state_q <= lmie_pkg::ST_WAIT;
        end
      endcase
    end
  end

  // Instruction decode
  logic fire;
  lmie_pkg::op_t op;
  logic [15:0] arg;
  lmie_pkg::mm_t mm;
  logic ind_n;
  logic [15:0] sel_fsp;
  logic [15:0] eff_addr;
  logic [15:0] fsp_next;
  logic fsp_upd;
  logic mem_we;
  logic [12:0] direct_addr;

  assign fire = wr_done && (paddr == `LMIE_OFF_INSTR);
  assign op = lmie_pkg::op_t'(pwdata[`LMIE_OP_LSB +: `LMIE_OP_W]);
  assign arg = pwdata[15:0];
  assign mm = lmie_pkg::mm_t'(arg[`LMIE_MM_LSB +: 2]);
  assign direct_addr = {bank_q, arg[6:0]};

  always_comb begin
    ind_n = 1'b0;
    eff_addr = 16'h0000;
    fsp_next = 16'h0000;
    fsp_upd = 1'b0;
    mem_we = 1'b0;
    sel_fsp = 16'h0000;
    case (op)
      lmie_pkg::OP_STORE_WORKING_TO_FILE: begin
        mem_we = fire;
        eff_addr = {3'h0, direct_addr};
        if (arg[6:0] == `LMIE_WIN0_ADDR || arg[6:0] == `LMIE_WIN1_ADDR) begin
          ind_n = arg[0];
          eff_addr = fsp_q[ind_n];
        end
      end
      lmie_pkg::OP_STORE_WORKING_INDIRECT: begin
        ind_n = arg[`LMIE_IND_N_BIT];
        sel_fsp = fsp_q[ind_n];
        mem_we = fire;
        fsp_upd = fire;
        case (mm)
          lmie_pkg::MM_PRE_INC: begin
            fsp_next = ptr_add(sel_fsp, 16'h0001);
            eff_addr = fsp_next;
          end
          lmie_pkg::MM_PRE_DEC: begin
            fsp_next = ptr_add(sel_fsp, 16'hffff);
            eff_addr = fsp_next;
          end
          lmie_pkg::MM_POST_INC: begin
            fsp_next = ptr_add(sel_fsp, 16'h0001);
            eff_addr = sel_fsp;
          end
          default: begin
            fsp_next = ptr_add(sel_fsp, 16'hffff);
            eff_addr = sel_fsp;
          end
        endcase
      end
      lmie_pkg::OP_STORE_WORKING_RELATIVE: begin
        ind_n = arg[`LMIE_REL_N_BIT];
        sel_fsp = fsp_q[ind_n];
        mem_we = fire;
        // Offset sign-extended from 6 bits; pointer itself is left alone
        eff_addr = ptr_add(sel_fsp, {{10{arg[5]}}, arg[5:0]});
      end
      default: begin
        eff_addr = 16'h0000;
      end
    endcase
  end

  logic sw_rst;
  assign sw_rst = fire && (op == lmie_pkg::OP_SOFTWARE_RESET);

  // Literal loads; software reset returns core state to its reset values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      work_q <= `LMIE_RST_WORK;
    end else if (sw_rst) begin
      work_q <= `LMIE_RST_WORK;
    end else if (fire && op == lmie_pkg::OP_LOAD_WORKING_LITERAL) begin
      work_q <= arg[7:0];
    end else if (wr_done && paddr == `LMIE_OFF_WORK) begin
      work_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_q <= `LMIE_RST_BANK;
    end else if (sw_rst) begin
      bank_q <= `LMIE_RST_BANK;
    end else if (fire && op == lmie_pkg::OP_LOAD_BANK_LITERAL) begin
      bank_q <= arg[5:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_q <= `LMIE_RST_PAGE;
    end else if (sw_rst) begin
      page_q <= `LMIE_RST_PAGE;
    end else if (fire && op == lmie_pkg::OP_LOAD_PAGE_LATCH_LITERAL) begin
      page_q <= arg[6:0];
    end
  end

  // Pointers: indirect update wins over a plain register write
  for (genvar i = 0; i < 2; i++) begin : g_fsp
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        fsp_q[i] <= `LMIE_RST_FSP;
      end else if (sw_rst) begin
        fsp_q[i] <= `LMIE_RST_FSP;
      end else if (fsp_upd && ind_n == 1'(i)) begin
        fsp_q[i] <= fsp_next;
      end else if (wr_done && paddr == (i == 0 ? `LMIE_OFF_FSP0 : `LMIE_OFF_FSP1)) begin
        fsp_q[i] <= pwdata[15:0];
      end
    end
  end

  // Flags follow software writes; of the instructions, only the software reset touches them, clearing them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= `LMIE_RST_FLAGS;
    end else if (sw_rst) begin
      flags_q <= `LMIE_RST_FLAGS;
    end else if (wr_done && paddr == `LMIE_OFF_FLAGS) begin
      flags_q <= pwdata[2:0];
    end
  end

  // Reset-instruction flag is cleared by the software reset it records
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ri_q <= `LMIE_RST_RI;
    end else if (sw_rst) begin
      ri_q <= 1'b0;
    end else if (wr_done && paddr == `LMIE_OFF_POWER_CONTROL_STATUS_REGISTER && pwdata[0]) begin
      ri_q <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_reset_q <= 1'b0;
    end else begin
      soft_reset_q <= sw_rst;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      maddr_q <= '0;
    end else if (wr_done && paddr == `LMIE_OFF_MADDR) begin
      maddr_q <= pwdata[MEM_AW-1:0];
    end
  end

  // Memory is narrower than the pointer span when MEM_AW is below 16: upper address bits are dropped
  lmie_data_mem #(
    .AW(MEM_AW)
  ) u_mem (
    .clk(pclk),
    .we(mem_we),
    .waddr(eff_addr[MEM_AW-1:0]),
    .wdata(work_q),
    .raddr(maddr_q),
    .rdata_q(mdata)
  );

  // Read data and error are prepared in the wait cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel && penable && state_q == lmie_pkg::ST_WAIT) begin
      pslverr_q <= !mapped(paddr);
      case (paddr)
        `LMIE_OFF_WORK: prdata_q <= {24'h0, work_q};
        `LMIE_OFF_BANK: prdata_q <= {26'h0, bank_q};
        `LMIE_OFF_PAGE: prdata_q <= {25'h0, page_q};
        `LMIE_OFF_FSP0: prdata_q <= {16'h0, fsp_q[0]};
        `LMIE_OFF_FSP1: prdata_q <= {16'h0, fsp_q[1]};
        `LMIE_OFF_FLAGS: prdata_q <= {29'h0, flags_q};
        `LMIE_OFF_POWER_CONTROL_STATUS_REGISTER: prdata_q <= {31'h0, ri_q};
        `LMIE_OFF_MADDR: prdata_q <= 32'(maddr_q);
        `LMIE_OFF_MDATA: prdata_q <= {24'h0, mdata};
        default: prdata_q <= 32'h0000_0000;
      endcase
    end else begin
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end
  end

  assign prdata = prdata_q;
  assign pready = state_q[1]; // One-hot answer bit, so pready leaves a flop directly
  assign pslverr = pslverr_q;
  assign bank_select_register = bank_q;
  assign program_counter_high_latch = page_q;
  assign soft_reset = soft_reset_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_bank_load: assert property (fire && op == lmie_pkg::OP_LOAD_BANK_LITERAL |=>
    bank_q == $past(arg[5:0]) && $stable(flags_q)) else $error("bank load wrong");
  a_page_load: assert property (fire && op == lmie_pkg::OP_LOAD_PAGE_LATCH_LITERAL |=>
    page_q == $past(arg[6:0])) else $error("page latch load wrong");
  a_work_load: assert property (fire && op == lmie_pkg::OP_LOAD_WORKING_LITERAL |=>
    work_q == $past(arg[7:0])) else $error("working load wrong");
  a_store_file: assert property (fire && op == lmie_pkg::OP_STORE_WORKING_TO_FILE && arg[6:1] != 6'h0
    |-> mem_we && eff_addr == {3'h0, bank_q, arg[6:0]}) else $error("direct store wrong");
  a_store_ind: assert property (fire && op == lmie_pkg::OP_STORE_WORKING_INDIRECT
    |-> mem_we && sel_fsp == fsp_q[arg[2]]) else $error("indirect store pointer wrong");
  a_pre_mode: assert property (fire && op == lmie_pkg::OP_STORE_WORKING_INDIRECT && !arg[1]
    |-> eff_addr == fsp_next ##1 fsp_q[$past(ind_n)] == $past(eff_addr)) else $error("pre mode wrong");
  a_post_mode: assert property (fire && op == lmie_pkg::OP_STORE_WORKING_INDIRECT && arg[1]
    |-> eff_addr == sel_fsp ##1 fsp_q[$past(ind_n)] != $past(eff_addr)) else $error("post mode wrong");
  a_rel_keep: assert property (fire && op == lmie_pkg::OP_STORE_WORKING_RELATIVE |=>
    fsp_q[$past(ind_n)] == $past(sel_fsp)) else $error("relative store moved pointer");
  a_win_redir: assert property (fire && op == lmie_pkg::OP_STORE_WORKING_TO_FILE && arg[6:1] == 6'h0
    |-> eff_addr == fsp_q[arg[0]]) else $error("window not redirected");
  a_ptr_wrap: assert property (fsp_upd && mm == lmie_pkg::MM_PRE_INC && sel_fsp == 16'hffff
    |=> fsp_q[$past(ind_n)] == 16'h0000) else $error("pointer did not wrap");
  a_flags_kept: assert property (fire && !sw_rst |=> $stable(flags_q)) else $error("flags changed");
  a_soft_reset: assert property (sw_rst |=> soft_reset_q && !ri_q && work_q == `LMIE_RST_WORK
    ##1 !soft_reset_q) else $error("software reset wrong");
  a_nop_quiet: assert property (fire && op == lmie_pkg::OP_NO_OPERATION |=> $stable(work_q)
    && $stable(bank_q) && $stable(page_q) && $stable(fsp_q[0]) && $stable(fsp_q[1])) else $error("no-op changed state");

endmodule : literal_move_indirect_exec

`default_nettype wire

// ### tb/tb_top.sv
// Purpose: Self-checking bench for the move/indirect executor over APB
// Assumes: MEM_AW=8; one wait state per transfer; instruction runs at its completing edge
// Notes: Expected values are worked out here from the instruction rules
`include "lmie_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] bank;
  logic [6:0] page;
  logic soft_reset;
  int failures = 0;
  int cmp_count = 0;
  int sr_count = 0;
  logic [31:0] rdat;
  logic rerr;
  logic [15:0] p, ea, np;
  logic [7:0] wv;
  logic [15:0] ptab [4] = '{16'hffff, 16'h0000, 16'hffff, 16'h0000};

  literal_move_indirect_exec #(.MEM_AW(8)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bank_select_register(bank), .program_counter_high_latch(page), .soft_reset(soft_reset)
  );

  always #5 pclk = ~pclk;

  // Registered pulse, so counting at the edge is race free
  always @(posedge pclk) begin
    if (soft_reset === 1'b1) sr_count++;
  end

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic rdy;
    int n;
    rdy = 1'b0;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Sampled at the rising edge, before that edge's own updates land
    while (!rdy && n < 50) begin
      @(posedge pclk);
      rdy = (pready === 1'b1);
      n++;
    end
    rdat = prdata;
    rerr = pslverr;
    if (!rdy) failures++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rchk

  task automatic ins(input lmie_pkg::op_t op, input logic [15:0] arg);
    wr(`LMIE_OFF_INSTR, {12'h000, op, arg});
  endtask : ins

  task automatic mchk(input logic [7:0] a, input logic [7:0] e);
    wr(`LMIE_OFF_MADDR, {24'h0, a});
    rchk(`LMIE_OFF_MDATA, {24'h0, e});
  endtask : mchk

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test

  initial begin
    repeat (6000) @(posedge pclk);
    failures++;
    finish_test();
  end

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and refused addresses
    rchk(`LMIE_OFF_WORK, 32'h0);
    rchk(`LMIE_OFF_FSP0, 32'h0);
    rchk(`LMIE_OFF_POWER_CONTROL_STATUS_REGISTER, 32'h1);
    rchk(8'h40, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    rchk(8'h05, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    // All flags set so that any disturbance shows
    wr(`LMIE_OFF_FLAGS, 32'h7);
    // Operand bits above the field must be dropped
    // Pins are looked at only after a later transfer, once the load edge has settled
    ins(lmie_pkg::OP_LOAD_BANK_LITERAL, 16'h00ea);
    rchk(`LMIE_OFF_BANK, 32'h2a);
    chk({31'h0, rerr}, 32'h0);
    chk({26'h0, bank}, 32'h2a);
    ins(lmie_pkg::OP_LOAD_PAGE_LATCH_LITERAL, 16'h00ff);
    rchk(`LMIE_OFF_PAGE, 32'h7f);
    chk({25'h0, page}, 32'h7f);
    ins(lmie_pkg::OP_LOAD_WORKING_LITERAL, 16'h015a);
    rchk(`LMIE_OFF_WORK, 32'h5a);
    rchk(`LMIE_OFF_FLAGS, 32'h7);
    // Direct store lands at bank and file address, low 8 bits kept by memory
    ins(lmie_pkg::OP_STORE_WORKING_TO_FILE, 16'h0015);
    mchk(8'h15, 8'h5a);
    rchk(`LMIE_OFF_FLAGS, 32'h7);
    // Every mode on both pointers, each placed at a wrap boundary
    for (int n = 0; n < 2; n++) begin
      for (int m = 0; m < 4; m++) begin
        p = ptab[m];
        wv = 8'(8'h10 + m + 4 * n);
        ea = (m == 0) ? p + 16'h1 : (m == 1) ? p - 16'h1 : p;
        np = (m == 0 || m == 2) ? p + 16'h1 : p - 16'h1;
        wr(8'(`LMIE_OFF_FSP0 + 4 * n), {16'h0, p});
        ins(lmie_pkg::OP_LOAD_WORKING_LITERAL, {8'h0, wv});
        ins(lmie_pkg::OP_STORE_WORKING_INDIRECT, {13'h0, n[0], m[1:0]});
        mchk(ea[7:0], wv);
        rchk(8'(`LMIE_OFF_FSP0 + 4 * n), {16'h0, np});
      end
    end
    rchk(`LMIE_OFF_FLAGS, 32'h7);
    // Relative form at both ends of the offset range
    wr(`LMIE_OFF_FSP1, 32'h0040);
    ins(lmie_pkg::OP_LOAD_WORKING_LITERAL, 16'h00a1);
    ins(lmie_pkg::OP_STORE_WORKING_RELATIVE, 16'h0060);
    mchk(8'h20, 8'ha1);
    ins(lmie_pkg::OP_STORE_WORKING_RELATIVE, 16'h005f);
    mchk(8'h5f, 8'ha1);
    rchk(`LMIE_OFF_FSP1, 32'h0040);
    // Window addresses go through their pointer
    wr(`LMIE_OFF_FSP0, 32'h0077);
    ins(lmie_pkg::OP_LOAD_WORKING_LITERAL, 16'h0033);
    ins(lmie_pkg::OP_STORE_WORKING_TO_FILE, 16'h0000);
    mchk(8'h77, 8'h33);
    ins(lmie_pkg::OP_STORE_WORKING_TO_FILE, 16'h0001);
    mchk(8'h40, 8'h33);
    rchk(`LMIE_OFF_FSP0, 32'h0077);
    // No-operation with a busy operand field still changes nothing
    ins(lmie_pkg::OP_NO_OPERATION, 16'hffff);
    rchk(`LMIE_OFF_WORK, 32'h33);
    rchk(`LMIE_OFF_FSP1, 32'h0040);
    rchk(`LMIE_OFF_FLAGS, 32'h7);
    chk({26'h0, bank}, 32'h2a);
    // Software reset clears state and the flag, keeps memory, pulses once
    ins(lmie_pkg::OP_SOFTWARE_RESET, 16'h0000);
    repeat (3) @(posedge pclk);
    chk(32'(sr_count), 32'h1);
    rchk(`LMIE_OFF_POWER_CONTROL_STATUS_REGISTER, 32'h0);
    rchk(`LMIE_OFF_WORK, 32'h0);
    rchk(`LMIE_OFF_FSP0, 32'h0);
    rchk(`LMIE_OFF_FLAGS, 32'h0);
    chk({19'h0, bank, page}, 32'h0);
    mchk(8'h77, 8'h33);
    rchk(`LMIE_OFF_MADDR, 32'h77);
    // Reset-instruction flag is write-one-to-set
    wr(`LMIE_OFF_POWER_CONTROL_STATUS_REGISTER, 32'h1);
    rchk(`LMIE_OFF_POWER_CONTROL_STATUS_REGISTER, 32'h1);
    finish_test();
  end
endmodule : tb_top

`default_nettype wire
